// ### logic/pms_map.svh
// Offsets, field positions, reset values and timing counts of the power mode supervisor.
`ifndef PMS_MAP_SVH
`define PMS_MAP_SVH

`define PMS_CLK_MHZ          20

`define PMS_OFF_MODE_CTRL    12'h000
`define PMS_OFF_MODE_STAT    12'h004
`define PMS_OFF_IRQ_FLAG3    12'h008
`define PMS_OFF_IRQ_EN       12'h00C

`define PMS_CTRL_IDLE_BIT    0
`define PMS_CTRL_STOP_BIT    1
`define PMS_CTRL_SLEEP_BIT   2
`define PMS_FLAG_UV_BIT      0
`define PMS_FLAG_OV_BIT      1
`define PMS_STAT_SUPPLY_BIT  8

`define PMS_IRQ_EN_RESET     2'h0
`define PMS_FLAGS_RESET      2'h0

`define PMS_T_UV_DEB_MS      30
`define PMS_T_OV_DEB_US      50
`define PMS_T_POR_US         500
`define PMS_T_SLEEP_EXIT_US  250
`define PMS_T_LIN_WAKE_US    15
`define PMS_T_HV_WAKE_US     25

`define PMS_CYC_UV_DEB       (`PMS_T_UV_DEB_MS * 1000 * `PMS_CLK_MHZ)
`define PMS_CYC_OV_DEB       (`PMS_T_OV_DEB_US * `PMS_CLK_MHZ)
`define PMS_CYC_POR          (`PMS_T_POR_US * `PMS_CLK_MHZ)
`define PMS_CYC_SLEEP_EXIT   (`PMS_T_SLEEP_EXIT_US * `PMS_CLK_MHZ)
`define PMS_CYC_LIN_WAKE     (`PMS_T_LIN_WAKE_US * `PMS_CLK_MHZ)
`define PMS_CYC_HV_WAKE      (`PMS_T_HV_WAKE_US * `PMS_CLK_MHZ)

`endif

// ### logic/pms_pkg.sv
// Types shared by the power mode supervisor modules.
package pms_pkg;

  typedef enum logic [6:0] {
    PMS_ST_RESET     = 7'b000_0001,
    PMS_ST_POR_WAIT  = 7'b000_0010,
    PMS_ST_NORMAL    = 7'b000_0100,
    PMS_ST_IDLE      = 7'b000_1000,
    PMS_ST_STOP      = 7'b001_0000,
    PMS_ST_SLEEP     = 7'b010_0000,
    PMS_ST_WAKE_WAIT = 7'b100_0000
  } pms_state_e;

  typedef struct packed {
    logic dig_rst_n;
    logic dig_supply_en;
    logic ana_supply_en;
    logic main_osc_en;
    logic slow_clk_sel;
    logic cpu_power_en;
    logic periph_en;
    logic lin_en;
    logic aux_supply_sel;
    logic wake_det_en;
  } pms_ctrl_s;

endpackage : pms_pkg

// ### logic/pms_filt_if.sv
// Carrier between the supervisor and one of its persistence filters.
`timescale 1ns/1ps
interface pms_filt_if;
  logic level;
  logic enable;
  logic qual;

  modport filt (input level, input enable, output qual);
  modport ctl  (output level, output enable, input qual);
endinterface : pms_filt_if

// ### logic/pms_filter.sv
// Persistence filter: qualifies a level only after it has held for LIMIT clock cycles.
`timescale 1ns/1ps
module pms_filter #(
  parameter int unsigned LIMIT = 1
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Filtered signal
  pms_filt_if.filt f
);
  localparam int CW = (LIMIT > 1) ? $clog2(LIMIT) : 1;

  logic [CW-1:0] cnt_q;
  logic          qual_q;
  wire logic     active = f.enable & f.level;
  wire logic     full   = (cnt_q == CW'(LIMIT - 1));

  // A drop of the level or of the enable restarts the window.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q  <= '0;
      qual_q <= 1'b0;
    end else begin
      cnt_q  <= (!active) ? '0 : (full ? cnt_q : cnt_q + CW'(1));
      qual_q <= active & full;
    end
  end

  assign f.qual = qual_q;
endmodule : pms_filter

// ### logic/pms_supervisor.sv
// Power mode supervisor with AHB-Lite register slave, supply fault filters and sleep wake-up.
//
// Local design decisions: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "pms_map.svh"

//////////////////////////////////////////////////////////////////////////////////////////////////
// Function
// RL1: battery below critical level: reset, whole chip and both regulators off.
// RL2: normal mode: processor and analogue circuitry fully operational.
// RL3: idle only by software request; digital logic may run on slow clock.
// RL4: idle blocks timers, second serial port, two-wire controller and link.
// RL5: external interrupts wake idle back to execution.
// RL6: stop only by software request; main oscillator off, link off.
// RL7: sleep request powers down processor, digital and analogue supplies.
// RL8: in sleep only wake logic runs, fed from the auxiliary supply.
// RL9: debounced under-voltage sets flag in third interrupt flag register.
// RL10: debounced over-voltage sets flag in third interrupt flag register.
// RL11: under-voltage must persist 10 to 60 ms, typically 30 ms.
// RL12: over-voltage must persist 50 to 100 us before flagging.
// RL13: internal reset released within 500 us after supply valid.
// RL14: internal reset released within 250 us after sleep wake-up.
// RL15: link wake needs dominant level through 15 to 150 us window.
// RL16: high-voltage pin wake needs an edge surviving 25 to 50 us.
// RL17: reset release always enters normal mode with main oscillator running.
// RL18: fault flags stay set until software clears; each can raise interrupt.
module pms_supervisor
  import pms_pkg::*;
#(
  parameter int unsigned UV_DEB_CYC    = `PMS_CYC_UV_DEB,
  parameter int unsigned POR_CYC       = `PMS_CYC_POR,
  parameter int unsigned SLEEP_EXIT_CYC = `PMS_CYC_SLEEP_EXIT,
  parameter int unsigned HV_PINS       = 4
) (
  // Clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  // Supply monitors and wake sources
  input  wire logic               battery_supply_ok,
  input  wire logic               uv_detect,
  input  wire logic               ov_detect,
  input  wire logic               lin_rx,
  input  wire logic [HV_PINS-1:0] high_voltage_pin,
  input  wire logic               ext_irq,
  // Power and clock controls
  output logic                    dig_rst_n,
  output logic                    dig_supply_en,
  output logic                    ana_supply_en,
  output logic                    main_rc_oscillator_en,
  output logic                    slow_clk_sel,
  output logic                    cpu_power_en,
  output logic                    periph_en,
  output logic                    lin_en,
  output logic                    auxiliary_supply_sel,
  // Interrupts to the processor
  output logic                    uv_irq,
  output logic                    ov_irq
);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Mode outputs per state.

  function automatic pms_ctrl_s mode_ctrl(input pms_state_e st);
    pms_ctrl_s c;
    c = '0;
    case (st)
      PMS_ST_RESET: begin
        // RL1 all off
        c = '0;
      end
      PMS_ST_POR_WAIT, PMS_ST_WAKE_WAIT: begin
        c.dig_supply_en = 1'b1;
        c.ana_supply_en = 1'b1;
        c.main_osc_en   = 1'b1;
        c.cpu_power_en  = 1'b1;
      end
      PMS_ST_NORMAL: begin
        // RL2 everything running
        c = '1;
        c.slow_clk_sel   = 1'b0;
        c.aux_supply_sel = 1'b0;
        c.wake_det_en    = 1'b0;
      end
      PMS_ST_IDLE: begin
        // RL3 slow clock, RL4 peripherals and link off
        c = '1;
        c.periph_en      = 1'b0;
        c.lin_en         = 1'b0;
        c.aux_supply_sel = 1'b0;
        c.wake_det_en    = 1'b0;
      end
      PMS_ST_STOP: begin
        // RL6 oscillator and link off
        c.dig_rst_n     = 1'b1;
        c.dig_supply_en = 1'b1;
        c.ana_supply_en = 1'b1;
        c.cpu_power_en  = 1'b1;
      end
      PMS_ST_SLEEP: begin
        // RL7 supplies off, RL8 wake logic on auxiliary supply
        c.aux_supply_sel = 1'b1;
        c.wake_det_en    = 1'b1;
      end
      default: c = '0;
    endcase
    return c;
  endfunction : mode_ctrl

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Bus slave: writes take zero wait states, reads insert one wait state.

  logic [11:0] addr_q;
  logic        wr_pend_q;
  logic        rd_pend_q;
  logic [31:0] hrdata_q;
  logic        hreadyout_q;
  logic [1:0]  irq_en_q;
  logic [1:0]  flags_q;
  logic [1:0]  flags_d;
  logic        uv_irq_q;
  logic        ov_irq_q;
  pms_state_e  state_q;
  pms_state_e  state_d;
  pms_ctrl_s   ctrl_q;

  wire logic        take     = hsel & htrans[1] & hready;
  wire logic        wr_ctrl  = wr_pend_q & (addr_q == `PMS_OFF_MODE_CTRL);
  wire logic        wr_flag  = wr_pend_q & (addr_q == `PMS_OFF_IRQ_FLAG3);
  wire logic        wr_en    = wr_pend_q & (addr_q == `PMS_OFF_IRQ_EN);
  wire logic        req_idle  = wr_ctrl & hwdata[`PMS_CTRL_IDLE_BIT];
  wire logic        req_stop  = wr_ctrl & hwdata[`PMS_CTRL_STOP_BIT];
  wire logic        req_sleep = wr_ctrl & hwdata[`PMS_CTRL_SLEEP_BIT];
  wire logic [31:0] stat_word = {23'h00_0000, battery_supply_ok, 1'b0, 7'(state_q)};
  wire logic [31:0] rd_mux    = (addr_q == `PMS_OFF_MODE_STAT) ? stat_word :
                                (addr_q == `PMS_OFF_IRQ_FLAG3) ? {30'h0000_0000, flags_q} :
                                (addr_q == `PMS_OFF_IRQ_EN)    ? {30'h0000_0000, irq_en_q} :
                                32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q      <= 12'h000;
      wr_pend_q   <= 1'b0;
      rd_pend_q   <= 1'b0;
      hrdata_q    <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      irq_en_q    <= `PMS_IRQ_EN_RESET;
    end else begin
      if (take) begin
        addr_q <= haddr[11:0];
      end
      wr_pend_q   <= take & hwrite;
      rd_pend_q   <= take & ~hwrite;
      hreadyout_q <= ~(take & ~hwrite);
      if (rd_pend_q) begin
        hrdata_q <= rd_mux;
      end
      if (wr_en) begin
        irq_en_q <= hwdata[1:0];
      end
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = 1'b0;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Persistence filters for supply faults and wake sources.

  pms_filt_if uv_if ();
  pms_filt_if ov_if ();
  pms_filt_if lin_if ();
  logic [HV_PINS-1:0] hv_ref_q;
  logic [HV_PINS-1:0] hv_qual;
  logic               uv_seen_q;
  logic               ov_seen_q;

  // RL11 under-voltage window
  assign uv_if.level  = uv_detect;
  assign uv_if.enable = ~state_q[0];
  pms_filter #(.LIMIT(UV_DEB_CYC)) u_uv_filt (.hclk(hclk), .hresetn(hresetn), .f(uv_if));

  // RL12 over-voltage window
  assign ov_if.level  = ov_detect;
  assign ov_if.enable = ~state_q[0];
  pms_filter #(.LIMIT(`PMS_CYC_OV_DEB)) u_ov_filt (.hclk(hclk), .hresetn(hresetn), .f(ov_if));

  // RL15 dominant link level must hold through the window
  assign lin_if.level  = ~lin_rx;
  assign lin_if.enable = ctrl_q.wake_det_en;
  pms_filter #(.LIMIT(`PMS_CYC_LIN_WAKE)) u_lin_filt (.hclk(hclk), .hresetn(hresetn), .f(lin_if));

  generate
    for (genvar i = 0; i < HV_PINS; i++) begin : g_hv
      pms_filt_if hv_if ();
      // RL16 a changed pin level must survive the window
      assign hv_if.level  = high_voltage_pin[i] ^ hv_ref_q[i];
      assign hv_if.enable = ctrl_q.wake_det_en;
      assign hv_qual[i]   = hv_if.qual;
      pms_filter #(.LIMIT(`PMS_CYC_HV_WAKE)) u_hv_filt (.hclk(hclk), .hresetn(hresetn), .f(hv_if));
    end
  endgenerate

  wire logic uv_set  = uv_if.qual & ~uv_seen_q;
  wire logic ov_set  = ov_if.qual & ~ov_seen_q;
  wire logic wake_sl = lin_if.qual | (|hv_qual);

  // RL9 RL10 RL18 sticky flags, write one to clear, a new event wins over the clear
  assign flags_d[`PMS_FLAG_UV_BIT] = uv_set |
                                     (flags_q[`PMS_FLAG_UV_BIT] & ~(wr_flag & hwdata[`PMS_FLAG_UV_BIT]));
  assign flags_d[`PMS_FLAG_OV_BIT] = ov_set |
                                     (flags_q[`PMS_FLAG_OV_BIT] & ~(wr_flag & hwdata[`PMS_FLAG_OV_BIT]));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q   <= `PMS_FLAGS_RESET;
      uv_seen_q <= 1'b0;
      ov_seen_q <= 1'b0;
      uv_irq_q  <= 1'b0;
      ov_irq_q  <= 1'b0;
    end else begin
      flags_q   <= flags_d;
      uv_seen_q <= uv_if.qual;
      ov_seen_q <= ov_if.qual;
      // RL18 each flag gated onto its own interrupt line
      uv_irq_q  <= flags_d[`PMS_FLAG_UV_BIT] & irq_en_q[`PMS_FLAG_UV_BIT];
      ov_irq_q  <= flags_d[`PMS_FLAG_OV_BIT] & irq_en_q[`PMS_FLAG_OV_BIT];
    end
  end

  assign uv_irq = uv_irq_q;
  assign ov_irq = ov_irq_q;

  // The pin reference follows the pins until sleep, so any edge during sleep shows as a mismatch.
  always_ff @(posedge hclk) begin
    if (state_q != PMS_ST_SLEEP) begin
      hv_ref_q <= high_voltage_pin;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Mode state machine and start-up timer.

  localparam int TW = $clog2(((POR_CYC > SLEEP_EXIT_CYC) ? POR_CYC : SLEEP_EXIT_CYC) + 1);

  logic [TW-1:0] tmr_q;
  wire logic     waiting  = (state_q == PMS_ST_POR_WAIT) | (state_q == PMS_ST_WAKE_WAIT);
  // RL13 RL14 reset release deadlines
  wire logic     tmr_done = (state_q == PMS_ST_POR_WAIT) ? (tmr_q >= TW'(POR_CYC - 1)) :
                                                           (tmr_q >= TW'(SLEEP_EXIT_CYC - 1));

  always_comb begin
    state_d = state_q;
    if (!battery_supply_ok) begin
      // RL1 supply loss overrides every mode
      state_d = PMS_ST_RESET;
    end else begin
      case (state_q)
        PMS_ST_RESET: begin
          state_d = PMS_ST_POR_WAIT;
        end
        PMS_ST_POR_WAIT, PMS_ST_WAKE_WAIT: begin
          // RL17 reset release always lands in normal mode
          if (tmr_done) state_d = PMS_ST_NORMAL;
        end
        PMS_ST_NORMAL: begin
          // RL3 RL6 RL7 software requests, sleep first
          if (req_sleep) state_d = PMS_ST_SLEEP;
          else if (req_stop) state_d = PMS_ST_STOP;
          else if (req_idle) state_d = PMS_ST_IDLE;
        end
        PMS_ST_IDLE, PMS_ST_STOP: begin
          // RL5 external interrupt resumes execution
          if (ext_irq) state_d = PMS_ST_NORMAL;
        end
        PMS_ST_SLEEP: begin
          if (wake_sl) state_d = PMS_ST_WAKE_WAIT;
        end
        default: state_d = PMS_ST_RESET;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= PMS_ST_RESET;
      tmr_q   <= '0;
      ctrl_q  <= '0;
    end else begin
      state_q <= state_d;
      tmr_q   <= (waiting && state_d == state_q) ? tmr_q + TW'(1) : '0;
      ctrl_q  <= mode_ctrl(state_d);
    end
  end

  assign dig_rst_n             = ctrl_q.dig_rst_n;
  assign dig_supply_en         = ctrl_q.dig_supply_en;
  assign ana_supply_en         = ctrl_q.ana_supply_en;
  assign main_rc_oscillator_en = ctrl_q.main_osc_en;
  assign slow_clk_sel          = ctrl_q.slow_clk_sel;
  assign cpu_power_en          = ctrl_q.cpu_power_en;
  assign periph_en             = ctrl_q.periph_en;
  assign lin_en                = ctrl_q.lin_en;
  assign auxiliary_supply_sel  = ctrl_q.aux_supply_sel;

endmodule : pms_supervisor

// ### tb/pms_asserts.sv
// Port-level assertions for the power mode supervisor.
`timescale 1ns/1ps
`include "pms_map.svh"
module pms_asserts #(
  parameter int unsigned UV_DEB_CYC     = 20,
  parameter int unsigned POR_CYC        = 30,
  parameter int unsigned SLEEP_EXIT_CYC = 25
) (
  // Clock, reset and bus
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  // Supply and wake inputs
  input wire logic       battery_supply_ok,
  input wire logic       uv_detect,
  input wire logic       ov_detect,
  input wire logic       ext_irq,
  // Power controls and interrupts
  input wire logic       dig_rst_n,
  input wire logic       dig_supply_en,
  input wire logic       ana_supply_en,
  input wire logic       main_rc_oscillator_en,
  input wire logic       slow_clk_sel,
  input wire logic       cpu_power_en,
  input wire logic       periph_en,
  input wire logic       lin_en,
  input wire logic       auxiliary_supply_sel,
  input wire logic       uv_irq,
  input wire logic       ov_irq
);
  int unsigned uv_run_q, ov_run_q, hold_q;
  logic        woke_q;

  // Run lengths of the faults and of the time spent waiting for reset release.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uv_run_q <= 0;
      ov_run_q <= 0;
      hold_q   <= 0;
      woke_q   <= 1'b0;
    end else begin
      uv_run_q <= $rose(uv_detect) ? 1 : (uv_detect ? uv_run_q + 1 : uv_run_q);
      ov_run_q <= $rose(ov_detect) ? 1 : (ov_detect ? ov_run_q + 1 : ov_run_q);
      hold_q   <= (dig_supply_en && !dig_rst_n) ? hold_q + 1 : 0;
      woke_q   <= $fell(auxiliary_supply_sel) || (woke_q && !dig_rst_n && dig_supply_en);
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rd_req;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_rd_ans;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_rd;
    s_rd_req |=> s_rd_ans;
  endproperty
  a_rd: assert property (p_rd)
    else $error("read wait state is not exactly one cycle");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay)
    else $error("bus response is not OKAY");
  property p_reset;
    !battery_supply_ok |=> {dig_rst_n, dig_supply_en, ana_supply_en, cpu_power_en} == 4'h0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("low battery did not power down the chip");
  property p_normal;
    lin_en |-> dig_rst_n && ana_supply_en && main_rc_oscillator_en && cpu_power_en && periph_en && !slow_clk_sel;
  endproperty
  a_normal: assert property (p_normal)
    else $error("link enabled outside full normal mode");
  property p_idle_in;
    $rose(slow_clk_sel) |-> $past(lin_en);
  endproperty
  a_idle_in: assert property (p_idle_in)
    else $error("idle entered from outside normal mode");
  property p_idle_blk;
    slow_clk_sel |-> !periph_en && !lin_en;
  endproperty
  a_idle_blk: assert property (p_idle_blk)
    else $error("peripherals or link active in idle");
  property p_idle_wake;
    slow_clk_sel && ext_irq && battery_supply_ok |=> lin_en;
  endproperty
  a_idle_wake: assert property (p_idle_wake)
    else $error("external interrupt did not wake idle");
  property p_stop;
    dig_rst_n && !main_rc_oscillator_en |-> !lin_en && cpu_power_en;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop mode outputs wrong");
  property p_sleep;
    auxiliary_supply_sel |-> !(dig_rst_n || dig_supply_en || ana_supply_en || cpu_power_en || main_rc_oscillator_en);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("supplies left on in sleep");
  property p_uv;
    $rose(uv_irq) |-> uv_run_q >= UV_DEB_CYC;
  endproperty
  a_uv: assert property (p_uv)
    else $error("under-voltage raised before debounce");
  property p_ov;
    $rose(ov_irq) |-> ov_run_q >= `PMS_CYC_OV_DEB;
  endproperty
  a_ov: assert property (p_ov)
    else $error("over-voltage raised before debounce");
  property p_por;
    hold_q <= POR_CYC + 1;
  endproperty
  a_por: assert property (p_por)
    else $error("reset held too long after power-on");
  property p_wake;
    woke_q |-> hold_q <= SLEEP_EXIT_CYC + 1;
  endproperty
  a_wake: assert property (p_wake)
    else $error("reset held too long after sleep exit");
  property p_start;
    $rose(dig_rst_n) |-> lin_en && main_rc_oscillator_en;
  endproperty
  a_start: assert property (p_start)
    else $error("reset release not into normal mode");
endmodule : pms_asserts

// ### tb/testbench.sv
// Self-checking bench of the power mode supervisor.
`timescale 1ns/1ps
module testbench;
  localparam logic [8:0] M_NORM = 9'h1EE, M_IDLE = 9'h1F8, M_STOP = 9'h1C8, M_SLP = 9'h001, M_WAIT = 9'h0E8;
  localparam int         POR    = 30;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, battery_supply_ok, uv_detect, ov_detect;
  logic        lin_rx, ext_irq, dig_rst_n, dig_supply_en, ana_supply_en, main_rc_oscillator_en, slow_clk_sel;
  logic        cpu_power_en, periph_en, lin_en, auxiliary_supply_sel, uv_irq, ov_irq;
  logic [1:0]  htrans;
  logic [3:0]  high_voltage_pin;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [8:0]  mode;
  int          bad_count, n_checks, cyc;

  assign mode = {dig_rst_n, dig_supply_en, ana_supply_en, main_rc_oscillator_en, slow_clk_sel,
                 cpu_power_en, periph_en, lin_en, auxiliary_supply_sel};

  pms_supervisor #(.UV_DEB_CYC(20), .POR_CYC(POR), .SLEEP_EXIT_CYC(25)) DUT (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .battery_supply_ok, .uv_detect, .ov_detect, .lin_rx, .high_voltage_pin, .ext_irq,
    .dig_rst_n, .dig_supply_en, .ana_supply_en, .main_rc_oscillator_en, .slow_clk_sel, .cpu_power_en,
    .periph_en, .lin_en, .auxiliary_supply_sel, .uv_irq, .ov_irq);

  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task cyc_n(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc_n

  // One single transfer; entered just after a rising edge.
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {20'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task wait_mode(input logic [8:0] e, input int lim);
    int n;
    n = 0;
    while (mode !== e && n < lim) begin
      @(posedge hclk);
      n++;
    end
    chk({23'h0, mode}, {23'h0, e});
  endtask : wait_mode

  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////////
  task t_boot;
    wait_mode(M_NORM, POR + 4);
    xfer(0, 12'h00C, 0); chk(rd, 0);
    xfer(0, 12'h008, 0); chk(rd, 0);
    xfer(0, 12'h010, 0); chk(rd, 0);
    xfer(0, 12'h004, 0); chk(rd, 32'h0000_0104);
  endtask : t_boot

  task t_idle_stop;
    xfer(1, 12'h000, 1); wait_mode(M_IDLE, 4);
    xfer(0, 12'h004, 0); chk(rd, 32'h0000_0108);
    ext_irq <= 1'b1; wait_mode(M_NORM, 4);
    ext_irq <= 1'b0;
    xfer(1, 12'h000, 2); wait_mode(M_STOP, 4);
    xfer(1, 12'h000, 1); cyc_n(3); chk({23'h0, mode}, {23'h0, M_STOP});
    ext_irq <= 1'b1; wait_mode(M_NORM, 4);
    ext_irq <= 1'b0;
  endtask : t_idle_stop

  task t_sleep;
    xfer(1, 12'h000, 7); wait_mode(M_SLP, 4);
    lin_rx <= 1'b0; cyc_n(200); lin_rx <= 1'b1; cyc_n(5);
    chk({23'h0, mode}, {23'h0, M_SLP});
    lin_rx <= 1'b0; wait_mode(M_WAIT, 310);
    lin_rx <= 1'b1; wait_mode(M_NORM, 28);
    xfer(1, 12'h000, 4); wait_mode(M_SLP, 4);
    high_voltage_pin <= 4'h4; cyc_n(200); high_voltage_pin <= 4'h0; cyc_n(5);
    chk({23'h0, mode}, {23'h0, M_SLP});
    high_voltage_pin <= 4'h4; wait_mode(M_WAIT, 510);
    wait_mode(M_NORM, 28);
    xfer(1, 12'h000, 4); wait_mode(M_SLP, 4);
    high_voltage_pin <= 4'h0; wait_mode(M_WAIT, 510);
    wait_mode(M_NORM, 28);
  endtask : t_sleep

  task t_faults;
    xfer(1, 12'h00C, 3);
    uv_detect <= 1'b1; cyc_n(10); uv_detect <= 1'b0; cyc_n(3);
    xfer(0, 12'h008, 0); chk(rd, 0);
    uv_detect <= 1'b1; cyc_n(25); uv_detect <= 1'b0; cyc_n(2);
    xfer(0, 12'h008, 0); chk(rd, 1);
    chk({31'h0, uv_irq}, 1);
    chk({23'h0, mode}, {23'h0, M_NORM});
    xfer(1, 12'h008, 1); xfer(0, 12'h008, 0); chk(rd, 0);
    ov_detect <= 1'b1; cyc_n(500); ov_detect <= 1'b0; cyc_n(3);
    xfer(0, 12'h008, 0); chk(rd, 0);
    ov_detect <= 1'b1; cyc_n(1010); ov_detect <= 1'b0; cyc_n(2);
    xfer(0, 12'h008, 0); chk(rd, 2);
    chk({31'h0, ov_irq}, 1);
    xfer(1, 12'h008, 2); xfer(0, 12'h008, 0); chk(rd, 0);
  endtask : t_faults

  task t_supply;
    battery_supply_ok <= 1'b0; cyc_n(3);
    chk({23'h0, mode}, 0);
    xfer(0, 12'h004, 0); chk(rd, 1);
    battery_supply_ok <= 1'b1; wait_mode(M_NORM, POR + 4);
  endtask : t_supply

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // A hang is cut short here and counted as a mismatch.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  initial begin
    {hresetn, hsel, hwrite, uv_detect, ov_detect, ext_irq} = 6'h0;
    {htrans, high_voltage_pin, haddr, hwdata} = 0;
    {lin_rx, battery_supply_ok} = 2'h3;
    cyc = 0;
    bad_count = 0;
    n_checks = 0;
    cyc_n(10);
    hresetn <= 1'b1;
    t_boot();
    t_idle_stop();
    t_sleep();
    t_faults();
    t_supply();
    report_and_stop();
  end
endmodule : testbench

bind pms_supervisor pms_asserts #(.UV_DEB_CYC(UV_DEB_CYC), .POR_CYC(POR_CYC), .SLEEP_EXIT_CYC(SLEEP_EXIT_CYC)) u_chk (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .battery_supply_ok, .uv_detect,
  .ov_detect, .ext_irq, .dig_rst_n, .dig_supply_en, .ana_supply_en, .main_rc_oscillator_en, .slow_clk_sel,
  .cpu_power_en, .periph_en, .lin_en, .auxiliary_supply_sel, .uv_irq, .ov_irq);
